/* include/ppm_regs.vh */
// Register offsets, field positions and map constants of the program page mapper.
// Included by the mapper RTL; holds definitions only.
`ifndef PPM_REGS_VH
`define PPM_REGS_VH
`define PPM_PAGE_SEL_ADDR 8'hca
`define PPM_WIN_BASE_ADDR 8'hc9
`define PPM_PAGE_LSB 0
`define PPM_PAGE_MSB 1
`define PPM_STATIC_PAGE 2'h1
`define PPM_PC_MSB 11
`define PPM_OFS_MSB 10
`define PPM_WIN_OFS_MSB 5
`define PPM_WIN_BASE_MSB 6
`define PPM_VEC_IRQ_SHIFT 3
`define PPM_VEC_PAIR_SHIFT 1
`define PPM_BANK_LO 8'h00
`define PPM_ADDR_ZERO 13'h0000
`define PPM_TOP_ZERO 12'h000
`define PPM_WIN_LO 8'h40
`define PPM_WIN_HI 8'h7f
`define PPM_BANK_HI 8'h3f
`define PPM_RAM_LO 8'h84
`define PPM_RAM_HI 8'hbf
`define PPM_VEC_IRQ 12'hff0
`define PPM_VEC_NMI 12'hffc
`define PPM_VEC_RST 12'hffe
`define PPM_STACK_DEPTH 6
`define PPM_SP_MAX 3'h6
`define PPM_SP_ZERO 3'h0
`define PPM_SP_ONE 3'h1
`endif

/* rtl/ppm_program_page_mapper.v */
// Program page mapper: program page translation, data-ROM window, data space decode
// and six-level return stack.
// Assumes the core drives data writes and fetches synchronously to ref_clk.
//
// Behaviour
// (RQ1) Program addresses come from a 12-bit program counter, 4K logical range.
// (RQ2) Physical program memory is four 2K pages, numbered 0 to 3.
// (RQ3) Program counter bit 11 set always selects static page 1.
// (RQ4) Bit 11 clear maps the lower half to the page-select page.
// (RQ5) Lower range page 1 aliases the static upper page storage.
// (RQ6) Page select sits at data address ca, written like RAM.
// (RQ7) Page select is write-only; no reads or single-bit operations on it.
// (RQ8) Only bits 1:0 of page select exist; bits 7:2 unused.
// (RQ9) Page select has no defined reset value; software writes it first.
// (RQ10) Interrupts and calls leave page select untouched, never saved.
// (RQ11) Vectors at ff0-ff7, ffc-ffd and ffe-fff lie in the static page.
// (RQ12) Software changes dynamic page only while running in the static page.
// (RQ13) Handlers keep a RAM image written before page select, if changed.
// (RQ14) Hardware return stack holds six 12-bit program counter values.
// (RQ15) Program memory constants readable through a 64-byte data window.
// (RQ16) Banked RAM and EEPROM, 64 bytes each, appear at data 00-3f.
// (RQ17) Sixty bytes of general RAM are always present in data space.
// (RQ18) The data-ROM window occupies data addresses 40 to 7f.
// (RQ19) Window address is the window base above the six low data bits.
// (RQ20) Physical address is the two-bit page above program counter bits 10:0.
// (RQ21) Page select holds until rewritten; new value serves later fetches.
`timescale 1ns/1ps
`include "ppm_regs.vh"

module ppm_program_page_mapper (
	input wire ref_clk,
	input wire nrst,
	input wire [11:0] program_counter,
	input wire data_wr,
	input wire data_rd,
	input wire [7:0] data_addr,
	input wire [7:0] data_wdata,
	input wire stack_push,
	input wire stack_pop,
	input wire [11:0] stack_push_value,
	output reg [12:0] prog_phys_addr,
	output reg prog_is_static,
	output reg prog_is_vector,
	output reg [12:0] window_phys_addr,
	output reg window_hit,
	output reg bank_hit,
	output reg ram_hit,
	output reg wo_read_err,
	output reg [11:0] stack_top,
	output reg stack_overflow,
	output reg stack_underflow
);

	// The page field and the window base have no reset value; software must write them first.
	reg [1:0] page_select_r;
	reg [6:0] data_window_base_reg_r;
	reg [11:0] stack_mem [0:`PPM_STACK_DEPTH-1];
	reg [2:0] sp_r;
	reg [2:0] sp_nxt;
	reg [1:0] page_nxt;
	wire pc_high;
	wire page_sel_wr;
	wire win_base_wr;
	wire win_sel;
	wire bank_sel;
	wire ram_sel;
	wire vec_sel;

	assign pc_high = program_counter[`PPM_PC_MSB]; // RQ1
	assign page_sel_wr = data_wr && (data_addr == `PPM_PAGE_SEL_ADDR); // RQ6
	assign win_base_wr = data_wr && (data_addr == `PPM_WIN_BASE_ADDR);
	assign vec_sel = pc_high &&
		((program_counter[`PPM_PC_MSB:`PPM_VEC_IRQ_SHIFT] == `PPM_VEC_IRQ >> `PPM_VEC_IRQ_SHIFT) ||
		(program_counter[`PPM_PC_MSB:`PPM_VEC_PAIR_SHIFT] == `PPM_VEC_NMI >> `PPM_VEC_PAIR_SHIFT) ||
		(program_counter[`PPM_PC_MSB:`PPM_VEC_PAIR_SHIFT] == `PPM_VEC_RST >> `PPM_VEC_PAIR_SHIFT)); // RQ11

	// Data-ROM window decode.
	ppm_range_hit #(
		.LO(`PPM_WIN_LO),
		.HI(`PPM_WIN_HI)
	) u_win_range (
		.addr(data_addr),
		.hit(win_sel)
	); // RQ18

	// Banked RAM and EEPROM decode at the bottom of data space.
	ppm_range_hit #(
		.LO(`PPM_BANK_LO),
		.HI(`PPM_BANK_HI)
	) u_bank_range (
		.addr(data_addr),
		.hit(bank_sel)
	); // RQ16

	// Always-present general RAM decode.
	ppm_range_hit #(
		.LO(`PPM_RAM_LO),
		.HI(`PPM_RAM_HI)
	) u_ram_range (
		.addr(data_addr),
		.hit(ram_sel)
	); // RQ17

	// Upper half always lands on the static page; lower half follows page select.
	always @* begin
		if (pc_high) begin
			page_nxt = `PPM_STATIC_PAGE; // RQ3
		end else begin
			page_nxt = page_select_r; // RQ4 RQ5
		end
	end

	// Page and window registers are left without reset on purpose.
	always @(posedge ref_clk) begin
		if (page_sel_wr) begin
			page_select_r <= data_wdata[`PPM_PAGE_MSB:`PPM_PAGE_LSB]; // RQ8 RQ9 RQ21
		end
		if (win_base_wr) begin
			data_window_base_reg_r <= data_wdata[`PPM_WIN_BASE_MSB:0];
		end
	end

	// Stack pointer counts used entries; push and pop in one cycle cancel in depth, except on an empty stack, which then holds one entry.
	always @* begin
		sp_nxt = sp_r;
		if (stack_push && !stack_pop && sp_r != `PPM_SP_MAX) begin
			sp_nxt = sp_r + `PPM_SP_ONE;
		end else if (stack_pop && !stack_push && sp_r != `PPM_SP_ZERO) begin
			sp_nxt = sp_r - `PPM_SP_ONE;
		end else if (stack_push && stack_pop && sp_r == `PPM_SP_ZERO) begin
			sp_nxt = `PPM_SP_ONE;
		end
	end

	always @(posedge ref_clk) begin
		if (stack_push) begin
			if (stack_pop && sp_r != `PPM_SP_ZERO) begin
				stack_mem[sp_r - `PPM_SP_ONE] <= stack_push_value; // RQ14
			end else if (sp_r != `PPM_SP_MAX) begin
				stack_mem[sp_r] <= stack_push_value; // RQ14
			end
		end
	end

	// Next values of the registered outputs.
	wire [12:0] prog_phys_addr_nxt;
	wire prog_is_static_nxt;
	wire prog_is_vector_nxt;
	wire [12:0] window_phys_addr_nxt;
	wire window_hit_nxt;
	wire bank_hit_nxt;
	wire ram_hit_nxt;
	wire wo_read_err_nxt;
	wire stack_overflow_nxt;
	wire stack_underflow_nxt;
	wire data_access;
	wire wo_addr;
	reg [11:0] stack_top_nxt;

	assign data_access = data_rd || data_wr;
	assign wo_addr = (data_addr == `PPM_PAGE_SEL_ADDR) || (data_addr == `PPM_WIN_BASE_ADDR);
	assign prog_phys_addr_nxt = {page_nxt, program_counter[`PPM_OFS_MSB:0]}; // RQ2 RQ20 RQ10
	assign prog_is_static_nxt = (page_nxt == `PPM_STATIC_PAGE); // RQ5
	assign prog_is_vector_nxt = vec_sel; // RQ11
	assign window_phys_addr_nxt = {data_window_base_reg_r, data_addr[`PPM_WIN_OFS_MSB:0]}; // RQ15 RQ19
	assign window_hit_nxt = data_rd && win_sel; // RQ15
	assign bank_hit_nxt = data_access && bank_sel; // RQ16
	assign ram_hit_nxt = data_access && ram_sel; // RQ17
	assign wo_read_err_nxt = data_rd && wo_addr; // RQ7
	assign stack_overflow_nxt = stack_push && !stack_pop && (sp_r == `PPM_SP_MAX);
	assign stack_underflow_nxt = stack_pop && !stack_push && (sp_r == `PPM_SP_ZERO);

	// A dropped overflow push leaves the old top visible.
	always @* begin
		stack_top_nxt = stack_mem[sp_nxt - `PPM_SP_ONE];
		if (sp_nxt == `PPM_SP_ZERO) begin
			stack_top_nxt = `PPM_TOP_ZERO;
		end else if (stack_push && (stack_pop || sp_r != `PPM_SP_MAX)) begin
			stack_top_nxt = stack_push_value; // RQ14
		end
	end

	always @(posedge ref_clk) begin
		if (!nrst) begin
			sp_r <= `PPM_SP_ZERO;
		end else begin
			sp_r <= sp_nxt;
		end
	end

	always @(posedge ref_clk) begin
		if (!nrst) begin
			prog_phys_addr <= `PPM_ADDR_ZERO;
		end else begin
			prog_phys_addr <= prog_phys_addr_nxt;
		end
	end

	always @(posedge ref_clk) begin
		if (!nrst) begin
			prog_is_static <= 1'b0;
		end else begin
			prog_is_static <= prog_is_static_nxt;
		end
	end

	always @(posedge ref_clk) begin
		if (!nrst) begin
			prog_is_vector <= 1'b0;
		end else begin
			prog_is_vector <= prog_is_vector_nxt;
		end
	end

	always @(posedge ref_clk) begin
		if (!nrst) begin
			window_phys_addr <= `PPM_ADDR_ZERO;
		end else begin
			window_phys_addr <= window_phys_addr_nxt;
		end
	end

	always @(posedge ref_clk) begin
		if (!nrst) begin
			window_hit <= 1'b0;
		end else begin
			window_hit <= window_hit_nxt;
		end
	end

	always @(posedge ref_clk) begin
		if (!nrst) begin
			bank_hit <= 1'b0;
		end else begin
			bank_hit <= bank_hit_nxt;
		end
	end

	always @(posedge ref_clk) begin
		if (!nrst) begin
			ram_hit <= 1'b0;
		end else begin
			ram_hit <= ram_hit_nxt;
		end
	end

	always @(posedge ref_clk) begin
		if (!nrst) begin
			wo_read_err <= 1'b0;
		end else begin
			wo_read_err <= wo_read_err_nxt;
		end
	end

	always @(posedge ref_clk) begin
		if (!nrst) begin
			stack_top <= `PPM_TOP_ZERO;
		end else begin
			stack_top <= stack_top_nxt;
		end
	end

	always @(posedge ref_clk) begin
		if (!nrst) begin
			stack_overflow <= 1'b0;
		end else begin
			stack_overflow <= stack_overflow_nxt;
		end
	end

	always @(posedge ref_clk) begin
		if (!nrst) begin
			stack_underflow <= 1'b0;
		end else begin
			stack_underflow <= stack_underflow_nxt;
		end
	end

endmodule

// Flags an 8-bit data address that lies inside an inclusive range.
module ppm_range_hit #(
	parameter [7:0] LO = 8'h00,
	parameter [7:0] HI = 8'hff
) (
	input wire [7:0] addr,
	output wire hit
);

	assign hit = (addr >= LO) && (addr <= HI);

endmodule

/* tb/ppm_checker_assertions.sv */
// Checker bound to the page mapper ports.
// Assumes ref_clk with the synchronous active-low nrst.
`timescale 1ns/1ps
module ppm_checker (
	input wire ref_clk, nrst, data_wr, data_rd, stack_push, stack_pop, prog_is_static,
	input wire prog_is_vector, window_hit, bank_hit, wo_read_err,
	input wire [7:0] data_addr, data_wdata,
	input wire [11:0] program_counter, stack_push_value, stack_top,
	input wire [12:0] prog_phys_addr
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	wire [11:0] pc = program_counter;
	a_static_page: assert property (pc[11] |=> prog_is_static && prog_phys_addr[12:11] == 2'h1)
		else $error("static page");
	a_pc_offset: assert property (1 |=> prog_phys_addr[10:0] == $past(pc[10:0]))
		else $error("offset");
	a_page_sel: assert property (data_wr && data_addr == 8'hca ##1 !pc[11]
		|=> prog_phys_addr[12:11] == $past(data_wdata[1:0], 2)) else $error("page");
	a_vector_flag: assert property (1 |=> prog_is_vector ==
		$past(pc[11:4] == 8'hff && (!pc[3] || pc[3:2] == 2'h3))) else $error("vector");
	a_wo_read: assert property (data_rd && data_addr == 8'hca |=> wo_read_err)
		else $error("read");
	a_window_hit: assert property (data_rd && data_addr[7:6] == 2'h1 |=> window_hit)
		else $error("window");
	a_bank_hit: assert property ((data_rd || data_wr) && data_addr[7:6] == 2'h0 |=> bank_hit)
		else $error("bank");
	a_stack_swap: assert property (stack_push && stack_pop |=> stack_top == $past(stack_push_value))
		else $error("stack");
endmodule
bind ppm_program_page_mapper ppm_checker u_chk (.*);

/* tb/ppm_core_model.sv */
// Core model: fetches, data accesses and stack operations, one per clock.
// Assumes each call starts 1 ns after a rising edge of ref_clk.
`timescale 1ns/1ps
module ppm_core_model (
	input wire ref_clk,
	output reg [11:0] program_counter, stack_push_value,
	output reg data_wr, data_rd, stack_push, stack_pop,
	output reg [7:0] data_addr, data_wdata
);
	initial {program_counter, stack_push_value, data_wr, data_rd, stack_push, stack_pop, data_addr, data_wdata} = 44'h0;
	// Released write data is inverted so a stale value never looks live.
	task cyc;
		@(posedge ref_clk);
		#1 {data_wr, data_rd, stack_push, stack_pop} = 4'h0;
		data_wdata = ~data_wdata;
	endtask
	task acc(input w, input [7:0] a, d);
		{data_wr, data_rd, data_addr, data_wdata} = {w, !w, a, d};
		cyc;
	endtask
	task fetch(input [11:0] p);
		program_counter = p;
		cyc;
	endtask
	task stk(input u, o, input [11:0] v);
		{stack_push, stack_pop, stack_push_value} = {u, o, v};
		cyc;
	endtask
endmodule

/* tb/ppm_program_page_mapper_bench.sv */
// Bench for the page mapper driven through the core model.
// Assumes registered outputs one clock after each request.
`timescale 1ns/1ps
module ppm_program_page_mapper_bench;
	reg ref_clk = 1'b0, nrst = 1'b0;
	wire [11:0] program_counter, stack_push_value, stack_top;
	wire data_wr, data_rd, stack_push, stack_pop, prog_is_static, prog_is_vector, window_hit, bank_hit;
	wire ram_hit, wo_read_err, stack_overflow, stack_underflow;
	wire [7:0] data_addr, data_wdata;
	wire [12:0] prog_phys_addr, window_phys_addr;
	integer fails = 0, checks_done = 0, i;
	always #20 ref_clk = ~ref_clk;
	ppm_core_model i_core (.*);
	ppm_program_page_mapper i_dut (.*);
	task chk(input [12:0] got, exp);
		checks_done = checks_done + 1;
		if (got !== exp) begin
			fails = fails + 1;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task flag(input got);
		chk({12'h0, got}, 13'h1);
	endtask
	task finish_test;
		if (fails == 0 && checks_done > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge ref_clk);
		#1 nrst = 1'b1;
		for (i = 0; i < 4; i = i + 1) begin
			i_core.fetch(12'h923);
			flag(prog_is_static);
			i_core.acc(1'b1, 8'hca, 8'hfc | i[7:0]);
			i_core.fetch(12'h123);
			chk(prog_phys_addr, {i[1:0], 11'h123});
		end
		for (i = 0; i < 7; i = i + 1) i_core.stk(1'b1, 1'b0, 12'h100 + i[11:0]);
		flag(stack_overflow);
		chk(stack_top, 13'h0105);
		i_core.stk(1'b1, 1'b1, 12'h456);
		chk(stack_top, 13'h0456);
		i_core.fetch(12'h010);
		chk(prog_phys_addr, 13'h1810);
		i_core.fetch(12'hffc);
		flag(prog_is_vector);
		i_core.fetch(12'hff8);
		chk({12'h0, prog_is_vector}, 13'h0);
		i_core.acc(1'b0, 8'hca, 8'h0);
		flag(wo_read_err);
		i_core.acc(1'b1, 8'hc9, 8'h85);
		i_core.acc(1'b0, 8'h47, 8'h0);
		chk(window_phys_addr, 13'h0147);
		flag(window_hit);
		i_core.acc(1'b0, 8'h3f, 8'h0);
		flag(bank_hit);
		i_core.acc(1'b1, 8'h84, 8'h0);
		flag(ram_hit);
		for (i = 0; i < 7; i = i + 1) i_core.stk(1'b0, 1'b1, 12'h0);
		flag(stack_underflow);
		chk(stack_top, 13'h0000);
		i_core.stk(1'b1, 1'b1, 12'h789);
		chk(stack_top, 13'h0789);
		finish_test;
	end
endmodule
